//--- design/pfmsr_top.sv
/*
 * Low-suction shutdown/restart retry and flow meter monitor of a pump drive.
 * Holds the flow parameter words, the pulse frequency gate, the analog
 * scaling and the retry sequencer. Assumes all inputs are synchronous to
 * i_clk_sys, that low-suction detection is done elsewhere, and that the
 * auxiliary voltage arrives already digitised in 0.01 V steps.
 */
//
// Notes on behaviour
// - Action 3: stop motor on low suction, restart after retry delay.
// - Retry only if detection enabled, action 3, no stop during delay.
// - Retry ignores and leaves untouched the auto-restart attempt counter.
// - Restart mode 0: speed search, no DC-injection braking.
// - Restart mode 1: no speed search, braking per braking setting.
// - Outputs with function code 28 turn on at low suction.
// - With action 3 the low-suction output drops once restarted.
// - Flow source: 0 off, 1 analog auxiliary, 2 pulse train.
// - Pulse mode measures pulse frequency, supported 50 Hz to 32 kHz.
// - Analog mode forces pulse and auxiliary settings, rejects their edits.
// - Selecting analog source invalidates previous auxiliary function.
// - Analog mode errors on PID target aux or PID sources on aux.
// - Analog 10 V maps to maximum flow, limited to 50000 GPM.
// - No-flow voltage maps to zero flow, settable 0.0 to 5.0 V.
// - Source 0 holds flow monitor at zero.
// - Flow monitor is read-only GPM value, 0 to 50000.
// - Pulse flow equals frequency times the sum of multiplier and offset.
// - Pulse mode errors on encoder control or pulse frequency command.
`timescale 1ns/10ps

module pfmsr_top
	import pfmsr_pkg::*;
#(
	parameter int SEC_CYCLES  = CYC_PER_SEC,   // Cycles per retry second
	parameter int GATE_CYCLES = CYC_PER_SEC,   // Pulse gate length
	parameter int DELAY_W     = 13             // Retry delay width
) (
	// Clock, reset, enable
	input  wire logic           i_clk_sys,
	input  wire logic           i_reset,
	input  wire logic           i_clk_en,
	// Parameter access port
	input  wire pfmsr_par_req_t i_par,
	output logic [15:0]         o_par_rdata,
	output logic                o_par_ack,
	output logic                o_par_reject,
	// Low-suction settings and events
	input  wire logic           i_suction_detect_en,
	input  wire logic           i_low_suction,
	input  wire logic [1:0]     i_suction_action_select,
	input  wire logic [DELAY_W-1:0] i_suction_retry_delay,
	input  wire logic           i_suction_restart_mode,
	input  wire logic           i_dc_braking_setting,
	input  wire logic           i_stop_cmd,
	input  wire logic           i_drive_running,
	input  wire logic [5:0]     i_mfo_function [NUM_MFO],
	// Neighbouring configuration
	input  wire pfmsr_cfg_t     i_cfg,
	// Flow sensor inputs
	input  wire logic [10:0]    i_aux_cv,
	input  wire logic           i_pulse,
	// Drive commands
	output logic                o_motor_stop,
	output pfmsr_restart_t      o_restart,
	output logic [NUM_MFO-1:0]  o_mfo_low_suction,
	// Flow status
	output logic [15:0]         o_flow_monitor_value,
	output logic                o_flow_setting_error,
	output logic                o_aux_params_forced,
	output logic                o_aux_function_invalidate,
	output logic                o_pulse_out_of_range
);

	// ==================================================================
	// Parameter words
	typedef enum {RS_IDLE, RS_WAIT, RS_RESTART} pfmsr_rs_t;

	logic [15:0] flow_source_select_r;
	logic [15:0] flow_max_at_full_scale_r;
	logic [15:0] flow_zero_voltage_r;
	logic [15:0] flow_pulse_multiplier_r;
	logic [15:0] flow_pulse_offset_r;
	logic [1:0]  src;
	logic        analog_mode;
	logic        pulse_mode;
	logic        wr_ok;
	logic        wr_bad;

	assign src         = flow_source_select_r[1:0];
	assign analog_mode = (src == SRC_AUX);
	assign pulse_mode  = (src == SRC_PULSE);

	// Write acceptance: range check, lock of the fixed words per mode
	always_comb begin
		wr_ok = 1'b0;
		case (i_par.addr)
			ADDR_FLOW_SRC:  wr_ok = (i_par.wdata <= {14'h0000, SRC_PULSE});
			ADDR_FLOW_MAX:  wr_ok = !pulse_mode && (i_par.wdata <= LIM_FLOW_MAX);
			ADDR_FLOW_ZERO: wr_ok = !pulse_mode && (i_par.wdata <= LIM_FLOW_ZERO);
			ADDR_FLOW_MULT: wr_ok = !analog_mode && (i_par.wdata >= LIM_MULT_MIN)
				&& (i_par.wdata <= LIM_MULT_MAX);
			ADDR_FLOW_OFS:  wr_ok = !analog_mode && (i_par.wdata <= LIM_OFS_MAX);
			default:        wr_ok = 1'b0;   // Monitor is read-only, others unmapped
		endcase
	end

	assign wr_bad = i_par.wr && !wr_ok;

	// Source selection word
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			flow_source_select_r <= {14'h0000, SRC_OFF};
		end else if (i_clk_en && i_par.wr && wr_ok && i_par.addr == ADDR_FLOW_SRC) begin
			flow_source_select_r <= i_par.wdata;
		end
	end

	// Analog scaling words; forced back to defaults while pulse mode owns them
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			flow_max_at_full_scale_r <= RST_FLOW_MAX;
			flow_zero_voltage_r      <= RST_FLOW_ZERO;
		end else if (i_clk_en) begin
			if (pulse_mode) begin
				flow_max_at_full_scale_r <= RST_FLOW_MAX;
				flow_zero_voltage_r      <= RST_FLOW_ZERO;
			end else if (i_par.wr && wr_ok) begin
				if (i_par.addr == ADDR_FLOW_MAX) begin
					flow_max_at_full_scale_r <= i_par.wdata;
				end
				if (i_par.addr == ADDR_FLOW_ZERO) begin
					flow_zero_voltage_r <= i_par.wdata;
				end
			end
		end
	end

	// Pulse scaling words; analog mode pins them at unity gain, zero offset
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			flow_pulse_multiplier_r <= RST_FLOW_MULT;
			flow_pulse_offset_r     <= RST_FLOW_OFS;
		end else if (i_clk_en) begin
			if (analog_mode) begin
				flow_pulse_multiplier_r <= FIX_MULT;
				flow_pulse_offset_r     <= FIX_OFS;
			end else if (i_par.wr && wr_ok) begin
				if (i_par.addr == ADDR_FLOW_MULT) begin
					flow_pulse_multiplier_r <= i_par.wdata;
				end
				if (i_par.addr == ADDR_FLOW_OFS) begin
					flow_pulse_offset_r <= i_par.wdata;
				end
			end
		end
	end

	// Read data, acknowledge and reject; answer one cycle after the request
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_par_rdata  <= 16'h0000;
			o_par_ack    <= 1'b0;
			o_par_reject <= 1'b0;
		end else if (i_clk_en) begin
			o_par_ack    <= i_par.wr || i_par.rd;
			o_par_reject <= wr_bad;
			if (i_par.rd) begin
				case (i_par.addr)
					ADDR_FLOW_MON:  o_par_rdata <= o_flow_monitor_value;
					ADDR_FLOW_SRC:  o_par_rdata <= flow_source_select_r;
					ADDR_FLOW_MAX:  o_par_rdata <= flow_max_at_full_scale_r;
					ADDR_FLOW_ZERO: o_par_rdata <= flow_zero_voltage_r;
					ADDR_FLOW_MULT: o_par_rdata <= flow_pulse_multiplier_r;
					ADDR_FLOW_OFS:  o_par_rdata <= flow_pulse_offset_r;
					default:        o_par_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ==================================================================
	// Pulse frequency gate
	logic        pulse_prev_r;
	logic [31:0] gate_cnt_r;
	logic [15:0] edge_cnt_r;
	logic [15:0] freq_hz_r;
	logic        gate_end;
	logic        pulse_rise;

	assign gate_end   = (gate_cnt_r == 32'(GATE_CYCLES - 1));
	assign pulse_rise = i_pulse && !pulse_prev_r;

	// Rising edges counted over a one-second gate give hertz directly;
	// the count saturates so an overspeed input cannot wrap to a low flow
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			pulse_prev_r <= 1'b0;
			gate_cnt_r   <= 32'h0000_0000;
			edge_cnt_r   <= 16'h0000;
			freq_hz_r    <= 16'h0000;
		end else if (i_clk_en) begin
			pulse_prev_r <= i_pulse;
			if (gate_end) begin
				gate_cnt_r <= 32'h0000_0000;
				// The closing cycle still counts, so the gate spans all its cycles
				freq_hz_r  <= (pulse_rise && edge_cnt_r != 16'hffff)
					? edge_cnt_r + 16'h0001 : edge_cnt_r;
				edge_cnt_r <= 16'h0000;
			end else begin
				gate_cnt_r <= gate_cnt_r + 32'h0000_0001;
				if (pulse_rise && edge_cnt_r != 16'hffff) begin
					edge_cnt_r <= edge_cnt_r + 16'h0001;
				end
			end
		end
	end

	// ==================================================================
	// Flow arithmetic
	logic [10:0] zero_cv;
	logic [10:0] aux_span;
	logic [26:0] aux_num;
	logic [15:0] flow_analog;
	logic [32:0] pulse_prod;
	logic [32:0] pulse_gpm;
	logic [15:0] flow_pulse;

	assign zero_cv  = 11'(flow_zero_voltage_r[5:0]) * 11'(ZERO_TO_CV);
	assign aux_span = AUX_FULL_SCALE - zero_cv;

	// Linear map from no-flow voltage to full scale; clamps at both ends
	always_comb begin
		aux_num     = 27'(flow_max_at_full_scale_r) * 27'(i_aux_cv - zero_cv);
		flow_analog = FLOW_ZERO_VAL;
		if (i_aux_cv <= zero_cv) begin
			flow_analog = FLOW_ZERO_VAL;
		end else if (i_aux_cv >= AUX_FULL_SCALE) begin
			flow_analog = flow_max_at_full_scale_r;
		end else begin
			flow_analog = 16'(aux_num / aux_span);
		end
	end

	// Multiplier and offset are both in hundredths, so sum then divide once
	always_comb begin
		pulse_prod = 33'(freq_hz_r)
			* (33'(flow_pulse_multiplier_r) + 33'(flow_pulse_offset_r));
		pulse_gpm  = pulse_prod / 33'(HUNDREDTHS);
		if (pulse_gpm > 33'(LIM_FLOW_MAX)) begin
			flow_pulse = LIM_FLOW_MAX;
		end else begin
			flow_pulse = pulse_gpm[15:0];
		end
	end

	// Flow monitor; pulse path refreshes when a gate closes or a pulse scaling word changes
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_flow_monitor_value <= FLOW_ZERO_VAL;
			o_pulse_out_of_range <= 1'b0;
		end else if (i_clk_en) begin
			case (src)
				SRC_AUX:   o_flow_monitor_value <= flow_analog;
				SRC_PULSE: o_flow_monitor_value <= flow_pulse;
				default:   o_flow_monitor_value <= FLOW_ZERO_VAL;
			endcase
			o_pulse_out_of_range <= pulse_mode
				&& (freq_hz_r < PULSE_MIN_HZ || freq_hz_r > PULSE_MAX_HZ);
		end
	end

	// ==================================================================
	// Configuration conflicts and auxiliary ownership
	logic [1:0] src_prev_r;

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_flow_setting_error      <= 1'b0;
			o_aux_params_forced       <= 1'b0;
			o_aux_function_invalidate <= 1'b0;
			src_prev_r                <= SRC_OFF;
		end else if (i_clk_en) begin
			src_prev_r <= src;
			o_flow_setting_error <= (analog_mode && (i_cfg.aux_function == AUX_PID_TARGET
				|| i_cfg.pid_setpoint_source == PID_SRC_AUX
				|| i_cfg.pid_feedback_source == PID_SRC_AUX))
				|| (pulse_mode && (i_cfg.encoder_speed_control != ENC_OFF
				|| i_cfg.freq_command_source == FREQ_SRC_PULSE));
			// Level tells the auxiliary block to hold its forced gain, bias, function
			o_aux_params_forced       <= analog_mode;
			o_aux_function_invalidate <= analog_mode && (src_prev_r != SRC_AUX);
		end
	end

	// ==================================================================
	// Low-suction retry sequencer
	pfmsr_rs_t          rs_r;
	logic [31:0]        sec_cnt_r;
	logic [DELAY_W-1:0] secs_r;
	logic               retry_armed;
	logic               ls_prev_r;
	logic               ls_rise;
	logic               delay_done;

	// Counter of the general auto-restart attempts is deliberately not wired here
	assign retry_armed = i_suction_detect_en
		&& (i_suction_action_select == ACT_RESTART);
	assign ls_rise     = i_low_suction && !ls_prev_r;
	assign delay_done  = (secs_r >= i_suction_retry_delay);

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			rs_r         <= RS_IDLE;
			sec_cnt_r    <= 32'h0000_0000;
			secs_r       <= '0;
			ls_prev_r    <= 1'b0;
			o_motor_stop <= 1'b0;
			o_restart    <= '0;
		end else if (i_clk_en) begin
			ls_prev_r       <= i_low_suction;
			o_restart.req   <= 1'b0;
			case (rs_r)
				RS_IDLE: begin
					if (ls_rise && retry_armed && !i_stop_cmd) begin
						rs_r         <= RS_WAIT;
						o_motor_stop <= 1'b1;
						sec_cnt_r    <= 32'h0000_0000;
						secs_r       <= '0;
					end
				end
				RS_WAIT: begin
					if (i_stop_cmd || !retry_armed) begin
						rs_r         <= RS_IDLE;
						o_motor_stop <= 1'b0;
					end else if (delay_done) begin
						rs_r                   <= RS_RESTART;
						o_motor_stop           <= 1'b0;
						o_restart.req          <= 1'b1;
						o_restart.speed_search <= (i_suction_restart_mode == RST_SPEED_SRCH);
						o_restart.dc_brake     <= (i_suction_restart_mode != RST_SPEED_SRCH)
							&& i_dc_braking_setting;
					end else if (sec_cnt_r == 32'(SEC_CYCLES - 1)) begin
						sec_cnt_r <= 32'h0000_0000;
						secs_r    <= secs_r + 1'b1;
					end else begin
						sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
					end
				end
				RS_RESTART: begin
					if (i_drive_running || i_stop_cmd) begin
						rs_r <= RS_IDLE;
					end
				end
				default: rs_r <= RS_IDLE;
			endcase
		end
	end

	// ==================================================================
	// Low-suction indication on multi-function outputs
	logic ls_ind_r;
	logic ls_clear;

	// Cleared by restart under action 3, otherwise by the detection going away
	assign ls_clear = (i_suction_action_select == ACT_RESTART)
		? (rs_r == RS_RESTART && i_drive_running)
		: !i_low_suction;

	// Set wins over clear so a fresh detection is never lost
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			ls_ind_r <= 1'b0;
		end else if (i_clk_en) begin
			if (ls_rise) begin
				ls_ind_r <= 1'b1;
			end else if (ls_clear) begin
				ls_ind_r <= 1'b0;
			end
		end
	end

	// Each output shows the indication only when its function code asks for it
	for (genvar g = 0; g < NUM_MFO; g++) begin : g_mfo
		always_ff @(posedge i_clk_sys or posedge i_reset) begin
			if (i_reset) begin
				o_mfo_low_suction[g] <= 1'b0;
			end else if (i_clk_en) begin
				o_mfo_low_suction[g] <= (i_mfo_function[g] == MFO_LOW_SUCTION)
					&& (ls_ind_r || ls_rise);
			end
		end
	end

endmodule

//--- design/pfmsr_pkg.sv
/*
 * Package for the pump flow meter and low-suction retry block: parameter
 * addresses, reset values, limits, encodings, timing figures and carriers.
 * Assumes a 10 MHz system clock and 16-bit parameter words.
 */
package pfmsr_pkg;

	// ==================================================================
	// Parameter addresses
	localparam logic [15:0] ADDR_FLOW_MON  = 16'h0047;
	localparam logic [15:0] ADDR_FLOW_SRC  = 16'h0880;
	localparam logic [15:0] ADDR_FLOW_MAX  = 16'h0881;
	localparam logic [15:0] ADDR_FLOW_ZERO = 16'h0882;
	localparam logic [15:0] ADDR_FLOW_MULT = 16'h0883;
	localparam logic [15:0] ADDR_FLOW_OFS  = 16'h0884;

	// ==================================================================
	// Reset values, limits and forced values
	localparam logic [15:0] RST_FLOW_MAX   = 16'h03e8;  // 1000 GPM
	localparam logic [15:0] RST_FLOW_ZERO  = 16'h0000;  // 0.0 V
	localparam logic [15:0] RST_FLOW_MULT  = 16'h2710;  // 100.00
	localparam logic [15:0] RST_FLOW_OFS   = 16'h0000;  // 0.00
	localparam logic [15:0] LIM_FLOW_MAX   = 16'hc350;  // 50000 GPM
	localparam logic [15:0] LIM_FLOW_ZERO  = 16'h0032;  // 5.0 V in 0.1 V
	localparam logic [15:0] LIM_MULT_MIN   = 16'h0001;  // 0.01
	localparam logic [15:0] LIM_MULT_MAX   = 16'hc350;  // 500.00
	localparam logic [15:0] LIM_OFS_MAX    = 16'h0063;  // 0.99
	localparam logic [15:0] FIX_MULT       = 16'h0064;  // 1.00 while analog
	localparam logic [15:0] FIX_OFS        = 16'h0000;
	localparam logic [15:0] FLOW_ZERO_VAL  = 16'h0000;

	// ==================================================================
	// Scaling of analog and pulse paths
	localparam logic [10:0] AUX_FULL_SCALE = 11'h3e8;   // 10.00 V in 0.01 V
	localparam logic [3:0]  ZERO_TO_CV     = 4'ha;      // 0.1 V to 0.01 V
	localparam logic [6:0]  HUNDREDTHS     = 7'h64;     // Multiplier scale
	localparam logic [15:0] PULSE_MIN_HZ   = 16'h0032;  // 50 Hz
	localparam logic [15:0] PULSE_MAX_HZ   = 16'h7d00;  // 32 kHz

	// ==================================================================
	// Encodings
	localparam logic [1:0] SRC_OFF         = 2'h0;
	localparam logic [1:0] SRC_AUX         = 2'h1;
	localparam logic [1:0] SRC_PULSE       = 2'h2;
	localparam logic [1:0] ACT_RESTART     = 2'h3;
	localparam logic       RST_SPEED_SRCH  = 1'h0;
	localparam logic [5:0] MFO_LOW_SUCTION = 6'h1c;     // Function code 28
	localparam logic [4:0] AUX_PID_TARGET  = 5'h09;
	localparam logic [2:0] PID_SRC_AUX     = 3'h3;
	localparam logic [2:0] FREQ_SRC_PULSE  = 3'h3;
	localparam logic [1:0] ENC_OFF         = 2'h0;
	localparam int         NUM_MFO         = 3;

	// ==================================================================
	// Timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int SECOND_S      = 1;                   // Retry and gate unit
	localparam int CYC_PER_SEC   = CLK_HZ * SECOND_S;

	// ==================================================================
	// Carriers
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} pfmsr_par_req_t;

	typedef struct packed {
		logic req;
		logic speed_search;
		logic dc_brake;
	} pfmsr_restart_t;

	typedef struct packed {
		logic [4:0] aux_function;
		logic [2:0] pid_setpoint_source;
		logic [2:0] pid_feedback_source;
		logic [1:0] encoder_speed_control;
		logic [2:0] freq_command_source;
	} pfmsr_cfg_t;

endpackage

//--- verification/pfmsr_sensor.sv
/*
 * Flow sensor model: square pulse train and digitised aux voltage.
 * Assumes the bench clock; a half period of 0 keeps the pulse line still.
 */
`timescale 1ns/10ps

module pfmsr_sensor (
	// Clock and setup
	input  wire logic        i_clk_sys,
	input  wire logic [7:0]  i_half,
	input  wire logic [10:0] i_volt,
	// Sensor lines
	output logic             o_pulse,
	output logic [10:0]      o_aux_cv
);
	logic [7:0] cnt_r;

	// =====
	// Start quiet
	initial begin
		cnt_r = 8'h00;
		o_pulse = 1'b0;
		o_aux_cv = 11'h000;
	end

	// Lines move just after the edge, so the drive never samples a change
	always @(posedge i_clk_sys) begin
		#1;
		o_aux_cv = i_volt;
		cnt_r = cnt_r + 8'h01;
		if (i_half == 8'h00) begin
			o_pulse = 1'b0;
			cnt_r = 8'h00;
		end else if (cnt_r >= i_half) begin
			o_pulse = ~o_pulse;
			cnt_r = 8'h00;
		end
	end
endmodule

//--- verification/pfmsr_top_asserts.sv
/*
 * Port checker for pfmsr_top: parameter refusals, retry sequencing, indication.
 * Assumes it is bound to every pfmsr_top and that the mode inputs stay still.
 */
`timescale 1ns/10ps

module pfmsr_top_asserts
	import pfmsr_pkg::*;
(
	// Watched ports
	input wire logic           i_clk_sys,
	input wire logic           i_reset,
	input wire logic           i_clk_en,
	input wire pfmsr_par_req_t i_par,
	input wire logic           o_par_ack,
	input wire logic           o_par_reject,
	input wire logic           i_suction_detect_en,
	input wire logic           i_low_suction,
	input wire logic [1:0]     i_suction_action_select,
	input wire logic           i_suction_restart_mode,
	input wire logic           i_dc_braking_setting,
	input wire logic           i_stop_cmd,
	input wire logic [5:0]     i_mfo_function [NUM_MFO],
	input wire logic           o_motor_stop,
	input wire pfmsr_restart_t o_restart,
	input wire logic [NUM_MFO-1:0] o_mfo_low_suction,
	input wire logic [15:0]    o_flow_monitor_value,
	input wire logic           o_aux_params_forced,
	input wire logic           o_aux_function_invalidate
);
	logic               tk;
	logic [NUM_MFO-1:0] hit;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	// =====
	// Helpers: a taken write, and which outputs carry the low-suction code
	assign tk = i_clk_en & i_par.wr;
	always_comb begin
		for (int k = 0; k < NUM_MFO; k++) begin
			hit[k] = (i_mfo_function[k] == MFO_LOW_SUCTION);
		end
	end

	// =====
	// Parameter refusals and auxiliary ownership
	ro_write_a: assert property (tk && i_par.addr == ADDR_FLOW_MON |=> o_par_ack && o_par_reject)
		else $error("monitor write not refused");
	src_range_a: assert property (tk && i_par.addr == ADDR_FLOW_SRC && i_par.wdata > 16'h0002
		|=> o_par_reject) else $error("bad source accepted");
	max_range_a: assert property (tk && i_par.addr == ADDR_FLOW_MAX && i_par.wdata > LIM_FLOW_MAX
		|=> o_par_reject) else $error("max flow over limit accepted");
	zero_range_a: assert property (tk && i_par.addr == ADDR_FLOW_ZERO && i_par.wdata > LIM_FLOW_ZERO
		|=> o_par_reject) else $error("no-flow voltage over limit accepted");
	inval_forced_a: assert property (o_aux_function_invalidate |-> o_aux_params_forced)
		else $error("invalidate outside analog mode");

	// =====
	// Retry sequencing, indication and monitor range
	shut_start_a: assert property ($rose(i_low_suction) && i_clk_en && i_suction_detect_en
		&& i_suction_action_select == ACT_RESTART && !i_stop_cmd && !o_motor_stop |=> o_motor_stop)
		else $error("motor not stopped");
	stop_cancel_a: assert property (i_stop_cmd && o_motor_stop |-> ##[1:3] !o_motor_stop)
		else $error("stop did not cancel");
	req_pulse_a: assert property (o_restart.req |-> !o_motor_stop ##1 !o_restart.req)
		else $error("restart request malformed");
	mode0_a: assert property (o_restart.req && !i_suction_restart_mode
		|-> o_restart.speed_search && !o_restart.dc_brake) else $error("mode 0 restart wrong");
	mode1_a: assert property (o_restart.req && i_suction_restart_mode |-> !o_restart.speed_search
		&& o_restart.dc_brake == i_dc_braking_setting) else $error("mode 1 restart wrong");
	mfo_code_a: assert property ((o_mfo_low_suction & ~hit) == '0)
		else $error("indication on a foreign output");
	flow_limit_a: assert property (o_flow_monitor_value <= LIM_FLOW_MAX)
		else $error("flow monitor over range");
endmodule

bind pfmsr_top pfmsr_top_asserts u_chk (.i_clk_sys, .i_reset, .i_clk_en, .i_par, .o_par_ack,
	.o_par_reject, .i_suction_detect_en, .i_low_suction, .i_suction_action_select,
	.i_suction_restart_mode, .i_dc_braking_setting, .i_stop_cmd, .i_mfo_function,
	.o_motor_stop, .o_restart, .o_mfo_low_suction, .o_flow_monitor_value,
	.o_aux_params_forced, .o_aux_function_invalidate);

//--- verification/pfmsr_bench.sv
/*
 * Bench for pfmsr_top: parameter port, analog and pulse flow, setting errors, retry.
 * Assumes a shortened second (100 cycles) and pulse gate (1000 cycles).
 */
`timescale 1ns/10ps

module pfmsr_bench
	import pfmsr_pkg::*;
;
	localparam int SEC  = 100;
	localparam int GATE = 1000;

	// =====
	// Signals
	logic           i_clk_sys, i_reset, ls, md, dc, stp, run, pul, ack, rej, mstop, serr;
	logic           forced, inv, oor;
	logic [5:0]     mfo [NUM_MFO];
	logic [7:0]     half;
	logic [10:0]    vset, aux;
	logic [15:0]    rdata, mon;
	logic [2:0]     mfol;
	pfmsr_par_req_t par;
	pfmsr_cfg_t     cfg;
	pfmsr_restart_t rs;
	int             bad_count, samples_checked, inv_n;

	// Relay and DO2 carry the low-suction code, DO1 does not
	assign mfo = '{MFO_LOW_SUCTION, 6'h05, MFO_LOW_SUCTION};

	pfmsr_top #(.SEC_CYCLES(SEC), .GATE_CYCLES(GATE)) DUT (.i_clk_sys(i_clk_sys),
		.i_reset(i_reset), .i_clk_en(1'b1), .i_par(par), .o_par_rdata(rdata), .o_par_ack(ack),
		.o_par_reject(rej), .i_suction_detect_en(1'b1), .i_low_suction(ls),
		.i_suction_action_select(ACT_RESTART), .i_suction_retry_delay(13'h0002),
		.i_suction_restart_mode(md), .i_dc_braking_setting(dc), .i_stop_cmd(stp),
		.i_drive_running(run), .i_mfo_function(mfo), .i_cfg(cfg), .i_aux_cv(aux),
		.i_pulse(pul), .o_motor_stop(mstop), .o_restart(rs), .o_mfo_low_suction(mfol),
		.o_flow_monitor_value(mon), .o_flow_setting_error(serr), .o_aux_params_forced(forced),
		.o_aux_function_invalidate(inv), .o_pulse_out_of_range(oor));

	pfmsr_sensor u_sen (.i_clk_sys(i_clk_sys), .i_half(half), .i_volt(vset), .o_pulse(pul),
		.o_aux_cv(aux));

	// =====
	// Clock, invalidate pulse counter and watchdog
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) if (inv === 1'b1) inv_n++;
	initial begin
		#5_000_000;
		bad_count++;
		results();
	end

	// =====
	// Tasks; every drive lands 1 ns after an edge
	task automatic results();
		if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	// One-cycle request, then a bounded wait for the acknowledge
	task automatic acc(input logic w, input logic [15:0] a, d);
		int n;
		tick(1);
		par = '{w, !w, a, d};
		tick(1);
		par = '0;
		n = 0;
		while (ack !== 1'b1 && n < 4) begin
			tick(1);
			n++;
		end
		chk(ack, 1'b1);
	endtask
	task automatic wr(input logic [15:0] a, d, input logic e);
		acc(1'b1, a, d);
		chk(rej, e);
	endtask
	task automatic rd(input logic [15:0] a, e);
		acc(1'b0, a, 16'h0000);
		chk(rdata, e);
	endtask
	task automatic fl(input logic [10:0] v, input logic [15:0] e);
		vset = v;
		tick(4);
		chk(mon, e);
	endtask
	task automatic ec(input pfmsr_cfg_t c, input logic e);
		cfg = c;
		tick(3);
		chk(serr, e);
	endtask
	// Two gates, the second a full one, must close after a change of pulse rate
	task automatic pw(input logic [7:0] h);
		half = h;
		tick(2 * GATE + 100);
	endtask
	// Low suction with a 2 s delay; a stop in the wait must cancel it
	task automatic retry(input logic m, b, cancel);
		int n;
		md = m;
		dc = b;
		tick(1);
		ls = 1'b1;
		tick(2);
		chk(mstop, 1'b1);
		chk(mfol, 3'h5);
		ls = 1'b0;
		run = 1'b0;
		stp = cancel;
		n = 2;
		while (rs.req !== 1'b1 && n < 3 * SEC) begin
			tick(1);
			n++;
		end
		chk(rs.req, !cancel);
		chk(mstop, 1'b0);
		if (!cancel) begin
			chk(n >= 2 * SEC && n <= 2 * SEC + 8, 1'b1);
			chk(rs.speed_search, !m);
			chk(rs.dc_brake, m && b);
		end
		stp = 1'b0;
		tick(1);
		run = 1'b1;
		tick(3);
		if (!cancel) chk(mfol, 3'h0);
	endtask

	// =====
	// Main sequence
	initial begin
		i_reset = 1'b1;
		par = '0;
		ls = 1'b0;
		md = 1'b0;
		dc = 1'b0;
		stp = 1'b0;
		run = 1'b1;
		cfg = '0;
		half = 8'h00;
		vset = 11'h000;
		tick(3);
		i_reset = 1'b0;
		rd(ADDR_FLOW_MAX, RST_FLOW_MAX);
		rd(ADDR_FLOW_ZERO, RST_FLOW_ZERO);
		rd(ADDR_FLOW_MULT, RST_FLOW_MULT);
		rd(ADDR_FLOW_OFS, RST_FLOW_OFS);
		rd(ADDR_FLOW_MON, FLOW_ZERO_VAL);
		rd(16'h0900, 16'h0000);
		wr(ADDR_FLOW_MON, 16'h0005, 1'b1);
		wr(16'h0900, 16'h0001, 1'b1);
		wr(ADDR_FLOW_SRC, 16'h0003, 1'b1);
		wr(ADDR_FLOW_MAX, 16'hc351, 1'b1);
		wr(ADDR_FLOW_ZERO, 16'h0033, 1'b1);
		wr(ADDR_FLOW_MULT, 16'h0000, 1'b1);
		wr(ADDR_FLOW_OFS, 16'h0064, 1'b1);
		wr(ADDR_FLOW_ZERO, 16'h0014, 1'b0);
		wr(ADDR_FLOW_SRC, 16'h0001, 1'b0);
		tick(3);
		chk(forced, 1'b1);
		chk(16'(inv_n), 16'h0001);
		rd(ADDR_FLOW_MULT, FIX_MULT);
		wr(ADDR_FLOW_MULT, 16'h00c8, 1'b1);
		wr(ADDR_FLOW_OFS, 16'h0001, 1'b1);
		fl(11'h0c8, 16'h0000);
		fl(11'h064, 16'h0000);
		fl(11'h258, 16'h01f4);
		fl(11'h5dc, 16'h03e8);
		wr(ADDR_FLOW_ZERO, 16'h0000, 1'b0);
		wr(ADDR_FLOW_MAX, LIM_FLOW_MAX, 1'b0);
		fl(11'h3e8, 16'hc350);
		fl(11'h1f4, 16'h61a8);
		ec('{AUX_PID_TARGET, 3'h0, 3'h0, ENC_OFF, 3'h0}, 1'b1);
		ec('{5'h00, PID_SRC_AUX, 3'h0, ENC_OFF, 3'h0}, 1'b1);
		ec('{5'h00, 3'h0, PID_SRC_AUX, ENC_OFF, 3'h0}, 1'b1);
		ec('0, 1'b0);
		wr(ADDR_FLOW_SRC, 16'h0002, 1'b0);
		wr(ADDR_FLOW_MAX, 16'h0005, 1'b1);
		wr(ADDR_FLOW_MULT, 16'h00c8, 1'b0);
		wr(ADDR_FLOW_OFS, 16'h0014, 1'b0);
		pw(8'h04);
		chk(mon, 16'h0113);
		chk(oor, 1'b0);
		ec('{5'h00, 3'h0, 3'h0, 2'h1, 3'h0}, 1'b1);
		ec('{5'h00, 3'h0, 3'h0, ENC_OFF, FREQ_SRC_PULSE}, 1'b1);
		ec('0, 1'b0);
		pw(8'h14);
		chk(oor, 1'b1);
		chk(mon, 16'h0037);
		wr(ADDR_FLOW_MULT, LIM_MULT_MAX, 1'b0);
		pw(8'h04);
		chk(mon, LIM_FLOW_MAX);
		wr(ADDR_FLOW_SRC, 16'h0000, 1'b0);
		tick(4);
		chk(mon, FLOW_ZERO_VAL);
		retry(1'b0, 1'b1, 1'b0);
		retry(1'b1, 1'b1, 1'b0);
		retry(1'b0, 1'b0, 1'b1);
		results();
	end
endmodule
